// file: logic/ggrc_pkg.sv
// Constants, types and register map of the gain guard and ripple calibration sequencer
// Summary of operation
// - Either input amplifier swinging too far sets input_clip_flag.
// - Input clipping held over 200 us restores default gain and sets gain_reset_flag.
// - gain_reset_disable blocks that automatic gain restore.
// - Output scaling picks 1, 1.25 or 1.375 V/V via output_scale_select bits.
// - Power-up and soft reset return output scaling to unity.
// - Output stage saturating to either rail sets output_clip_flag.
// - Either high-voltage supply below 8 V sets hv_supply_low_flag.
// - Calibration starts by itself at power-on, after supply fault, after soft reset.
// - Those automatic calibrations are always full, whatever the type selection.
// - During calibration the four input switches open, both test switches close.
// - After calibration every overridden switch returns to its mux setting, which a soft reset clears to the reset state.
// - Scheduled and triggered calibrations use the cal_type_select choice.
// - Full calibration steps through each amplifier in turn, about 85 ms.
// - Quick calibration handles all amplifiers at once, about 8 ms.
// - With defaults, only power-up, fault and reset calibrations happen.
// - A nonzero cal_schedule_rate repeats the selected calibration periodically.
// - Writing cal_trigger starts one calibration of the selected type.
// - Four-bit input_gain_code holds twelve steps and is restored by clip recovery.
// - With cal_busy_pin_enable and pin 2 an output, pin 2 shows calibration busy.
package ggrc_pkg;
    // Clock and timing
    localparam int CLK_MHZ       = 200;
    localparam int CLIP_TIME_US  = 200;
    localparam int FULL_CAL_MS   = 85;
    localparam int QUICK_CAL_MS  = 8;
    localparam int CLIP_CYC      = CLIP_TIME_US * CLK_MHZ;
    localparam int MS_CYC        = 1000 * CLK_MHZ;
    localparam int N_AMP         = 9;
    localparam int STEP_CYC      = (FULL_CAL_MS * MS_CYC) / N_AMP;
    localparam int QUICK_CYC     = QUICK_CAL_MS * MS_CYC;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_GAIN   = 8'h04;
    localparam logic [7:0] ADDR_MUX    = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_SCHED  = 8'h10;
    // Control fields
    localparam int CTRL_GRD   = 0;
    localparam int CTRL_QUICK = 1;
    localparam int CTRL_BUSY  = 2;
    localparam int CTRL_DIR2  = 3;
    localparam int CTRL_TRIG  = 4;
    localparam int CTRL_SRST  = 5;
    localparam logic [4:0] CTRL_RST = 5'h00;
    // Gain fields and defaults
    localparam int GAIN_SCL_LSB = 4;
    localparam logic [3:0] GAIN_CODE_DEF = 4'h0;
    localparam logic [3:0] GAIN_CODE_MAX = 4'hb;
    localparam logic [1:0] SCALE_UNITY   = 2'h0;
    localparam logic [1:0] SCALE_BAD     = 2'h3;
    // Status bits: 0 in clip, 1 gain reset, 2 out clip, 3 hv low
    localparam int ST_FLAGS = 4;
    // Schedule periods in ms, index is the rate code, 0 is off
    localparam logic [31:0] SCHED_MS [8] = '{32'h0, 32'h3e8, 32'h2710, 32'hea60,
        32'h493e0, 32'h36ee80, 32'h1499700, 32'h5265c00};
    typedef struct packed {
        logic a1;
        logic a2;
        logic b1;
        logic b2;
        logic c1;
        logic c2;
    } ggrc_sw_s;
    localparam ggrc_sw_s SW_RST = '{default: 1'b0};
    localparam ggrc_sw_s SW_CAL = '{a1: 1'b0, a2: 1'b0, b1: 1'b0, b2: 1'b0,
                                    c1: 1'b1, c2: 1'b1};
    typedef struct packed {
        logic in_clip;
        logic out_clip;
        logic hv_low;
    } ggrc_mon_s;
    typedef enum logic [1:0] {CAL_IDLE, CAL_FULL, CAL_QUICK} ggrc_cal_e;
endpackage

// file: logic/ggrc_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ggrc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,  // Clock
    input  wire logic         rst_i,  // Synchronous reset
    input  wire logic [W-1:0] d_i,    // Asynchronous input
    output logic      [W-1:0] q_o     // Synchronised output
);
    logic [W-1:0] meta_q;

    // First stage read only by the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            q_o    <= '0;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule

// file: logic/ggrc_timer.sv
// Cycle timer that pulses when a run of limit cycles completes
`timescale 1ns/1ps
module ggrc_timer #(
    parameter int W = 32
) (
    input  wire logic         clk_i,    // Clock
    input  wire logic         rst_i,    // Synchronous reset
    input  wire logic         run_i,    // Count while high, clear when low
    input  wire logic [W-1:0] limit_i,  // Cycles per period
    output logic              done_o    // Last cycle of each period
);
    logic [W-1:0] cnt_q;

    initial begin
        if (W < 2) $error("timer too narrow");
    end

    assign done_o = run_i && (cnt_q == limit_i - W'(1));

    // Wraps after each period so it can repeat
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i || done_o) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + W'(1);
        end
    end
endmodule

// file: logic/ggrc_top.sv
// Gain guard and ripple calibration sequencer with Wishbone register slave
`timescale 1ns/1ps
module ggrc_top
    import ggrc_pkg::*;
#(
    parameter int CLIP_CYCLES  = CLIP_CYC,   // Clip persistence time
    parameter int STEP_CYCLES  = STEP_CYC,   // Full calibration, per amplifier
    parameter int QUICK_CYCLES = QUICK_CYC,  // Quick calibration length
    parameter int MS_CYCLES    = MS_CYC      // Schedule tick
) (
    input  wire logic        clk_i,                   // 200 MHz clock
    input  wire logic        rst_i,                   // Power-up reset
    input  wire logic [7:0]  wb_adr_i,                // Byte address
    input  wire logic [31:0] wb_dat_i,                // Write data
    input  wire logic [3:0]  wb_sel_i,                // Byte enables
    input  wire logic        wb_we_i,                 // Write
    input  wire logic        wb_cyc_i,                // Cycle
    input  wire logic        wb_stb_i,                // Strobe
    output logic      [31:0] wb_dat_o,                // Read data
    output logic             wb_ack_o,                // Acknowledge
    input  wire logic        in_clip_a_i,             // Input amp A swing fault
    input  wire logic        in_clip_b_i,             // Input amp B swing fault
    input  wire logic        out_clip_pos_i,          // Output at upper rail
    input  wire logic        out_clip_neg_i,          // Output at lower rail
    input  wire logic        hv_low_pos_i,            // Positive HV supply under 8 V
    input  wire logic        hv_low_neg_i,            // Negative HV supply under 8 V
    output ggrc_pkg::ggrc_sw_s sw_o,                  // Input and test switch controls
    output logic      [3:0]  input_gain_code_o,       // Input gain step
    output logic             output_scale_select_lo_o, // 1.25 V/V scaling
    output logic             output_scale_select_hi_o, // 1.375 V/V scaling
    output logic             cal_busy_o,              // Calibration running
    output logic             cal_full_o,              // Running calibration is full
    output logic      [3:0]  cal_amp_o,               // Amplifier under calibration
    output logic             gpio2_o,                 // Pin 2 data
    output logic             gpio2_oe_o               // Pin 2 drive enable
);
    import ggrc_pkg::*;

    initial begin
        if (CLIP_CYCLES < 1 || STEP_CYCLES < 2 || QUICK_CYCLES < 2 || MS_CYCLES < 2)
            $error("timing parameters too small");
    end

    logic [4:0]  ctrl_q;
    logic [3:0]  gain_code_q;
    logic [1:0]  scale_q;
    ggrc_sw_s    mux_q;
    logic [2:0]  rate_q;
    logic [ST_FLAGS-1:0] flag_q;
    logic        soft_q;
    logic        full_pend_q;
    logic        sched_pend_q;
    logic        hv_prev_q;
    ggrc_cal_e   state_q;
    logic [3:0]  amp_q;
    logic [31:0] ms_cnt_q;
    logic [5:0]  raw_pins;
    logic [5:0]  pins;
    ggrc_mon_s   mon;
    logic        clip_done;
    logic        cal_tick;
    logic        ms_tick;
    logic        bus_req;
    logic        wr_en;
    logic        clr_all;
    logic        start;
    logic        cal_end;
    logic [31:0] cal_limit;
    logic [31:0] rd_data;

    // Pin inputs through two flops
    assign raw_pins = {in_clip_a_i, in_clip_b_i, out_clip_pos_i, out_clip_neg_i,
                       hv_low_pos_i, hv_low_neg_i};
    ggrc_sync #(.W(6)) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (raw_pins),
        .q_o   (pins)
    );
    assign mon.in_clip  = pins[5] | pins[4];
    assign mon.out_clip = pins[3] | pins[2];
    assign mon.hv_low   = pins[1] | pins[0];

    // Clip persistence, fires strictly after the limit
    ggrc_timer #(.W(32)) u_clip_tmr (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .run_i   (mon.in_clip),
        .limit_i (32'(CLIP_CYCLES + 1)),
        .done_o  (clip_done)
    );

    // Calibration phase timer
    assign cal_limit = (state_q == CAL_FULL) ? 32'(STEP_CYCLES) : 32'(QUICK_CYCLES);
    ggrc_timer #(.W(32)) u_cal_tmr (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .run_i   (state_q != CAL_IDLE),
        .limit_i (cal_limit),
        .done_o  (cal_tick)
    );

    // Millisecond tick for the schedule
    ggrc_timer #(.W(32)) u_ms_tmr (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .run_i   (rate_q != 3'h0),
        .limit_i (32'(MS_CYCLES)),
        .done_o  (ms_tick)
    );

    // Wishbone decode, one access per ack
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_en   = bus_req && wb_we_i && wb_sel_i[0];
    assign clr_all = rst_i || soft_q;

    // Read mux, unmapped reads zero
    always_comb begin
        rd_data = 32'h0;
        case (wb_adr_i)
            ADDR_CTRL:   rd_data = {27'h0, ctrl_q};
            ADDR_GAIN:   rd_data = {26'h0, scale_q, gain_code_q};
            ADDR_MUX:    rd_data = {26'h0, mux_q};
            ADDR_STATUS: rd_data = {23'h0, mon, state_q == CAL_FULL,
                                    state_q != CAL_IDLE, flag_q};
            ADDR_SCHED:  rd_data = {29'h0, rate_q};
            default:     rd_data = 32'h0;
        endcase
    end

    // Bus answer one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? rd_data : 32'h0;
        end
    end

    // Soft reset pulse
    always_ff @(posedge clk_i) begin
        if (clr_all) begin
            soft_q <= 1'b0;
        end else begin
            soft_q <= wr_en && wb_adr_i == ADDR_CTRL && wb_dat_i[CTRL_SRST];
        end
    end

    // Control register, trigger self-clears at start
    always_ff @(posedge clk_i) begin
        if (clr_all) begin
            ctrl_q <= CTRL_RST;
        end else if (wr_en && wb_adr_i == ADDR_CTRL) begin
            ctrl_q <= wb_dat_i[4:0];
        end else if (start && !full_pend_q) begin
            ctrl_q[CTRL_TRIG] <= 1'b0;
        end
    end

    // Gain register with clip recovery
    always_ff @(posedge clk_i) begin
        if (clr_all) begin
            gain_code_q <= GAIN_CODE_DEF;
            scale_q     <= SCALE_UNITY;
        end else if (clip_done && !ctrl_q[CTRL_GRD]) begin
            gain_code_q <= GAIN_CODE_DEF;
            scale_q     <= SCALE_UNITY;
        end else if (wr_en && wb_adr_i == ADDR_GAIN) begin
            if (wb_dat_i[3:0] <= GAIN_CODE_MAX)
                gain_code_q <= wb_dat_i[3:0];
            if (wb_dat_i[GAIN_SCL_LSB+:2] != SCALE_BAD)
                scale_q <= wb_dat_i[GAIN_SCL_LSB+:2];
        end
    end

    // Switch setting, frozen while a calibration owns the switches
    always_ff @(posedge clk_i) begin
        if (clr_all) begin
            mux_q <= SW_RST;
        end else if (wr_en && wb_adr_i == ADDR_MUX && state_q == CAL_IDLE) begin
            mux_q <= wb_dat_i[5:0];
        end
    end

    // Schedule rate
    always_ff @(posedge clk_i) begin
        if (clr_all) begin
            rate_q <= 3'h0;
        end else if (wr_en && wb_adr_i == ADDR_SCHED) begin
            rate_q <= wb_dat_i[2:0];
        end
    end

    // Sticky flags, hardware set wins over write-one clear
    always_ff @(posedge clk_i) begin
        if (clr_all) begin
            flag_q <= '0;
        end else begin
            flag_q <= (flag_q & ~((wr_en && wb_adr_i == ADDR_STATUS) ?
                                  wb_dat_i[ST_FLAGS-1:0] : 4'h0))
                    | {mon.hv_low,
                       mon.out_clip,
                       clip_done && !ctrl_q[CTRL_GRD],
                       mon.in_clip};
        end
    end

    // Schedule counter in milliseconds
    always_ff @(posedge clk_i) begin
        if (clr_all || rate_q == 3'h0) begin
            ms_cnt_q     <= 32'h0;
            sched_pend_q <= 1'b0;
        end else begin
            if (ms_tick) begin
                ms_cnt_q <= (ms_cnt_q == SCHED_MS[rate_q] - 32'h1) ? 32'h0
                                                                  : ms_cnt_q + 32'h1;
            end
            if (ms_tick && ms_cnt_q == SCHED_MS[rate_q] - 32'h1) begin
                sched_pend_q <= 1'b1;
            end else if (start && !full_pend_q) begin
                sched_pend_q <= 1'b0;
            end
        end
    end

    // Full calibration request from reset, soft reset or supply fault
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            full_pend_q <= 1'b1;
            hv_prev_q   <= 1'b0;
        end else begin
            hv_prev_q <= mon.hv_low;
            if (soft_q || (mon.hv_low && !hv_prev_q)) begin
                full_pend_q <= 1'b1;
            end else if (start) begin
                full_pend_q <= 1'b0;
            end
        end
    end

    // Start once idle, waiting out a supply fault
    assign start = state_q == CAL_IDLE && !mon.hv_low && !soft_q
                && (full_pend_q || ctrl_q[CTRL_TRIG] || sched_pend_q);
    assign cal_end = cal_tick
                  && (state_q == CAL_QUICK || amp_q == 4'(N_AMP - 1));

    // Calibration sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= CAL_IDLE;
            amp_q   <= 4'h0;
        end else begin
            case (state_q)
                CAL_IDLE: begin
                    amp_q <= 4'h0;
                    if (start && (full_pend_q || !ctrl_q[CTRL_QUICK]))
                        state_q <= CAL_FULL;
                    else if (start)
                        state_q <= CAL_QUICK;
                end
                CAL_FULL: begin
                    if (cal_end)
                        state_q <= CAL_IDLE;
                    else if (cal_tick)
                        amp_q <= amp_q + 4'h1;
                end
                CAL_QUICK: begin
                    if (cal_end)
                        state_q <= CAL_IDLE;
                end
                default: state_q <= CAL_IDLE;
            endcase
        end
    end

    // Registered outputs toward the analog side
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sw_o                     <= SW_RST;
            input_gain_code_o        <= GAIN_CODE_DEF;
            output_scale_select_lo_o <= 1'b0;
            output_scale_select_hi_o <= 1'b0;
            cal_busy_o               <= 1'b0;
            cal_full_o               <= 1'b0;
            cal_amp_o                <= 4'h0;
        end else begin
            sw_o <= (state_q != CAL_IDLE) ? SW_CAL : mux_q;
            input_gain_code_o        <= gain_code_q;
            output_scale_select_lo_o <= scale_q[0];
            output_scale_select_hi_o <= scale_q[1];
            cal_busy_o               <= state_q != CAL_IDLE;
            cal_full_o               <= state_q == CAL_FULL;
            cal_amp_o <= (state_q == CAL_QUICK) ? 4'hf : amp_q;
        end
    end

    // Pin 2 as calibration busy output
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gpio2_o    <= 1'b0;
            gpio2_oe_o <= 1'b0;
        end else begin
            gpio2_oe_o <= ctrl_q[CTRL_DIR2];
            gpio2_o    <= ctrl_q[CTRL_DIR2] && ctrl_q[CTRL_BUSY]
                       && state_q != CAL_IDLE;
        end
    end

    // Checks on the guarded behaviour
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    in_clip_flag_a: assert property (mon.in_clip && !soft_q |=> flag_q[0])
        else $error("input clip flag not set");
    gain_restore_a: assert property (clip_done && !ctrl_q[CTRL_GRD] && !soft_q
        |=> gain_code_q == GAIN_CODE_DEF && flag_q[1] ##1 input_gain_code_o == GAIN_CODE_DEF)
        else $error("gain not restored after clipping");
    restore_block_a: assert property (clip_done && ctrl_q[CTRL_GRD] && !wr_en
        && !soft_q |=> $stable(gain_code_q) && $stable(flag_q[1]))
        else $error("gain restored while disabled");
    scale_legal_a: assert property (scale_q != SCALE_BAD
        && !(output_scale_select_lo_o && output_scale_select_hi_o))
        else $error("illegal output scaling");
    soft_scale_a: assert property (soft_q |=> scale_q == SCALE_UNITY ##1
        !output_scale_select_lo_o && !output_scale_select_hi_o)
        else $error("scaling not unity after soft reset");
    out_clip_flag_a: assert property (mon.out_clip && !soft_q |=> flag_q[2])
        else $error("output clip flag not set");
    hv_low_flag_a: assert property ($rose(mon.hv_low) && !soft_q |=> flag_q[3])
        else $error("supply low flag not set");
    por_full_a: assert property ($fell(rst_i) |-> ##[0:1] state_q == CAL_FULL)
        else $error("no full calibration after power-up");
    auto_full_a: assert property (start && full_pend_q |=> state_q == CAL_FULL)
        else $error("automatic calibration not full");
    cal_switch_a: assert property (state_q != CAL_IDLE |=> sw_o == SW_CAL)
        else $error("switches not overridden in calibration");
    sw_return_a: assert property ($fell(cal_busy_o) |-> sw_o == $past(mux_q))
        else $error("switches not restored");
    quick_len_a: assert property ($rose(state_q == CAL_QUICK) |->
        (state_q == CAL_QUICK) [*2])
        else $error("quick calibration too short");
    trig_clear_a: assert property (start && !full_pend_q && !wr_en
        |=> !ctrl_q[CTRL_TRIG] && state_q != CAL_IDLE)
        else $error("trigger not consumed");
    busy_pin_a: assert property (ctrl_q[CTRL_DIR2] && ctrl_q[CTRL_BUSY]
        && $stable(ctrl_q) |=> gpio2_o == $past(state_q != CAL_IDLE))
        else $error("busy pin wrong");

    full_run_c: cover property (state_q == CAL_FULL ##1 state_q == CAL_IDLE);
    quick_run_c: cover property (state_q == CAL_QUICK ##1 state_q == CAL_IDLE);
    gain_reset_c: cover property (clip_done && !ctrl_q[CTRL_GRD]);
    sched_cal_c: cover property (sched_pend_q && start);
endmodule

// file: tb/tb_top.sv
// Self-checking testbench for the gain guard and ripple calibration sequencer
`timescale 1ns/1ps
module tb_top;
    import ggrc_pkg::*;
    localparam int CLIP = 20;
    localparam int STEP = 10;
    localparam int QUICK = 16;
    localparam int MS = 4;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] q;
    logic        we = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic [5:0]  pins = 6'h00;  // Clip a, b, out pos, neg, hv pos, neg
    logic [31:0] dat_o;
    logic        ack;
    ggrc_sw_s    sw;
    logic [3:0]  gcode;
    logic [3:0]  amp;
    logic        slo;
    logic        shi;
    logic        busy;
    logic        full;
    logic        g2;
    logic        g2oe;
    int          err_count = 0;
    int          comparisons = 0;
    int          cyc_n = 0;

    ggrc_top #(.CLIP_CYCLES(CLIP), .STEP_CYCLES(STEP), .QUICK_CYCLES(QUICK),
        .MS_CYCLES(MS)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .in_clip_a_i(pins[0]), .in_clip_b_i(pins[1]),
        .out_clip_pos_i(pins[2]), .out_clip_neg_i(pins[3]), .hv_low_pos_i(pins[4]),
        .hv_low_neg_i(pins[5]), .sw_o(sw), .input_gain_code_o(gcode),
        .output_scale_select_lo_o(slo), .output_scale_select_hi_o(shi),
        .cal_busy_o(busy), .cal_full_o(full), .cal_amp_o(amp), .gpio2_o(g2),
        .gpio2_oe_o(g2oe));

    // Clock and hang guard
    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 30000) begin
            err_count++;
            wrap_up();
        end
    end

    task automatic wrap_up;
        $display("counts: %0d comparisons, %0d mismatches", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One classic Wishbone cycle, held until ack is sampled
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk_i);
        adr <= a;
        we <= w;
        wdat <= d;
        cyc <= 1'b1;
        stb <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = dat_o;
        chk("ack", ack, 1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    // Waits for a calibration, judges its kind, length and switch handling
    task automatic cal_run(input logic f, input int wmax, input ggrc_sw_s after);
        int n;
        n = 0;
        while (busy !== 1'b1 && n < wmax) begin
            @(posedge clk_i);
            n++;
        end
        chk("cal switches", sw, SW_CAL);
        chk("cal full", full, f);
        chk("cal amp", amp, f ? 4'h0 : 4'hf);
        n = 0;
        while (busy === 1'b1 && n < 2000) begin
            @(posedge clk_i);
            n++;
        end
        chk("cal length", n, f ? 9 * STEP : QUICK);
        chk("restored switches", sw, after);
    endtask

    task automatic t_defaults;
        int hits;
        hits = 0;
        repeat (300) begin
            @(posedge clk_i);
            hits += (busy !== 1'b0);
        end
        chk("idle cals", hits, 0);
        wb(8'h14, 1'b0, 32'h0);
        chk("unmapped read", q, 0);
        $display("test defaults done");
    endtask

    task automatic t_trigger;
        wb(ADDR_MUX, 1'b1, 32'h2a);
        @(posedge clk_i);
        chk("mux", sw, 6'h2a);
        wb(ADDR_CTRL, 1'b1, 32'h1e);
        while (busy !== 1'b1 && cyc_n < 29000) @(posedge clk_i);
        chk("busy pin", {g2oe, g2}, 2'b11);
        cal_run(1'b0, 20, 6'h2a);
        wb(ADDR_CTRL, 1'b0, 32'h0);
        chk("trigger cleared", q, 32'h0e);
        chk("busy pin idle", g2, 0);
        wb(ADDR_CTRL, 1'b1, 32'h1c);
        cal_run(1'b1, 20, 6'h2a);
        $display("test trigger done");
    endtask

    task automatic t_clip;
        wb(ADDR_GAIN, 1'b1, 32'h1b);
        wb(ADDR_GAIN, 1'b1, 32'h3c);
        wb(ADDR_GAIN, 1'b0, 32'h0);
        chk("gain refused", q, 32'h1b);
        chk("scale", {shi, slo}, 2'b01);
        pins <= 6'h01;
        repeat (CLIP + 8) @(posedge clk_i);
        chk("gain restored", {shi, slo, gcode}, 6'h00);
        wb(ADDR_STATUS, 1'b0, 32'h0);
        chk("clip flags", q[1:0], 2'b11);
        wb(ADDR_CTRL, 1'b1, 32'h1);
        wb(ADDR_GAIN, 1'b1, 32'h1b);
        pins <= 6'h02;
        repeat (2 * CLIP + 8) @(posedge clk_i);
        chk("gain kept", gcode, 4'hb);
        pins <= 6'h00;
        wb(ADDR_CTRL, 1'b1, 32'h2);
        repeat (4) @(posedge clk_i);
        wb(ADDR_STATUS, 1'b1, 32'hf);
        $display("test clip done");
    endtask

    task automatic t_monitors;
        pins <= 6'h18;
        repeat (6) @(posedge clk_i);
        wb(ADDR_STATUS, 1'b0, 32'h0);
        chk("fault flags", q[8:0], 9'h0cc);
        chk("cal held", busy, 0);
        pins <= 6'h00;
        cal_run(1'b1, 20, 6'h2a);
        wb(ADDR_STATUS, 1'b1, 32'hf);
        wb(ADDR_STATUS, 1'b0, 32'h0);
        chk("flags cleared", q[3:0], 4'h0);
        $display("test monitors done");
    endtask

    task automatic t_soft;
        wb(ADDR_GAIN, 1'b1, 32'h25);
        @(posedge clk_i);
        chk("scale hi", {shi, slo}, 2'b10);
        wb(ADDR_CTRL, 1'b1, 32'h22);
        cal_run(1'b1, 20, SW_RST);
        chk("scale unity", {shi, slo}, 2'b00);
        wb(ADDR_CTRL, 1'b0, 32'h0);
        chk("ctrl reset", q, 32'h0);
        $display("test soft reset done");
    endtask

    task automatic t_sched;
        wb(ADDR_CTRL, 1'b1, 32'h2);
        wb(ADDR_SCHED, 1'b1, 32'h1);
        cal_run(1'b0, 1000 * MS + 50, SW_RST);
        wb(ADDR_SCHED, 1'b1, 32'h0);
        $display("test schedule done");
    endtask

    // Main sequence
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        cal_run(1'b1, 10, SW_RST);
        $display("test power on done");
        t_defaults();
        t_trigger();
        t_clip();
        t_monitors();
        t_soft();
        t_sched();
        wrap_up();
    end
endmodule
